//--- common/snc_pkg.sv
// Purpose: shared constants and types for the sinc3 decimation host
// Assumes: clk at 200 MHz, modulator clock made here by division
// Notes: all widths fixed at the documented values
package snc_pkg;

	// ==========================================================
	// timing
	localparam int SNC_CLK_PERIOD_NS = 5;
	localparam int SNC_MOD_PERIOD_NS = 50;
	// half a modulator period in clk cycles, rounded down, at least one
	localparam int SNC_MOD_HALF_INT = (SNC_MOD_PERIOD_NS / 2) / SNC_CLK_PERIOD_NS;
	localparam logic [7:0] SNC_MOD_HALF_CYC = (SNC_MOD_HALF_INT < 1) ? 8'h01 :
		8'(SNC_MOD_HALF_INT);
	localparam logic [7:0] SNC_MOD_HALF_LAST = SNC_MOD_HALF_CYC - 8'h01;

	// ==========================================================
	// widths
	localparam int SNC_ACC_W = 37;
	localparam int SNC_OUT_W = 16;
	localparam int SNC_CNT_W = 16;

	// ==========================================================
	// input mapping; bipolar maps a zero bit to minus one
	localparam logic SNC_BIPOLAR = 1'b0;
	localparam logic [36:0] SNC_SAMPLE_ONE = 37'h00_0000_0001;
	localparam logic [36:0] SNC_SAMPLE_ZERO = 37'h00_0000_0000;
	localparam logic [36:0] SNC_SAMPLE_NEG = 37'h1f_ffff_ffff;

	// ==========================================================
	// decimation ratios and output slice positions
	localparam logic [15:0] SNC_DR_32 = 16'h0020;
	localparam logic [15:0] SNC_DR_64 = 16'h0040;
	localparam logic [15:0] SNC_DR_128 = 16'h0080;
	localparam logic [15:0] SNC_DR_256 = 16'h0100;
	localparam logic [15:0] SNC_DR_512 = 16'h0200;
	localparam logic [15:0] SNC_DR_1024 = 16'h0400;
	localparam logic [15:0] SNC_DR_2048 = 16'h0800;
	localparam logic [15:0] SNC_DR_4096 = 16'h1000;
	localparam int SNC_LSB_64 = 2;
	localparam int SNC_LSB_128 = 5;
	localparam int SNC_LSB_256 = 8;
	localparam int SNC_LSB_512 = 11;
	localparam int SNC_LSB_1024 = 14;
	localparam int SNC_LSB_2048 = 17;
	localparam int SNC_LSB_4096 = 20;

	// ==========================================================
	// saturation
	localparam logic [15:0] SNC_SAT_LOW32 = 16'h8000;
	localparam logic [16:0] SNC_SAT_PATTERN = 17'h1_0000;
	localparam logic [15:0] SNC_SAT_WORD = 16'hffff;

	// ==========================================================
	// response corner, per mille of the word rate
	localparam int SNC_RESP_PER_MILLE = 262;
	localparam int SNC_FULL_BITS_AT_256 = 24;

	// ==========================================================
	// types
	typedef struct packed {
		logic [36:0] one;
		logic [36:0] two;
		logic [36:0] three;
	} snc_integ_t;

	typedef enum logic {SNC_ARMED, SNC_SPENT} snc_arm_t;

endpackage

//--- verilog/snc_comb_stage.sv
// Purpose: one comb differentiator of the sinc3 chain
// Assumes: load is a one-cycle event at the output word rate
// Notes: delay and result both clear on reset
`timescale 1ns/1ps
module snc_comb_stage
	import snc_pkg::*;
#(
	parameter int W = SNC_ACC_W
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic load,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	logic [W-1:0] delayed;

	// ==========================================================
	// difference against the value one word earlier
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			dout <= '0;
			delayed <= '0;
		end
		else if (load)
		begin
			dout <= din - delayed;
			delayed <= din;
		end
	end

	chk_comb_diff: assert property (@(posedge clk) disable iff (sys_rst)
		load |=> dout == $past(din) - $past(delayed))
		else $error("comb stage difference wrong");

endmodule // snc_comb_stage

//--- verilog/snc_filter_host.sv
// Purpose: host-side sinc3 decimation filter for a 1-bit sigma-delta stream
// Assumes: modulator clocked from this block, data sampled at rising edge
// Notes: output word register is never reset, by design
//
// Contract
// - each bit becomes a 37-bit sample
// - three integrators add on falling edge
// - counter wraps at ratio minus one
// - word clock high at half, low at end
// - three combs subtract previous word value
// - output slice chosen by decimation ratio
// - full-scale pattern saturates to all ones
// - output register loads per word, no reset
// - valid pulses once per word, arm alternates
// - accepts power-of-two ratios 32 to 4096
// - sample stream bits at rising edge
// - response corner is 0.262 word rate
// - word rate is clock over ratio
`timescale 1ns/1ps
module snc_filter_host
	import snc_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [15:0] decimation_ratio,
	input wire logic modulator_bit_output,
	output logic modulator_clock_input,
	output logic [15:0] filter_word,
	output logic word_valid
);

	// ==========================================================
	// internal state
	logic [7:0] half_cnt;
	logic half_end;
	logic rise_evt;
	logic fall_evt;
	logic [36:0] input_sample;
	snc_integ_t integ;
	logic [15:0] word_count;
	logic [15:0] ratio_last;
	logic [15:0] ratio_half;
	logic word_clk;
	logic word_evt;
	snc_arm_t arm;
	logic [36:0] comb_stage_one;
	logic [36:0] comb_stage_two;
	logic [36:0] comb_stage_three;
	logic [7:0] valid_run;

	// ==========================================================
	// output slice and saturation
	function automatic logic [15:0] snc_scale(input logic [15:0] r,
		input logic [36:0] d);
		logic [16:0] top;
		logic [15:0] w;
		top = d[SNC_LSB_256 +: 17];
		w = d[SNC_LSB_256 +: 16];
		case (r)
			SNC_DR_64:
			begin
				top = d[SNC_LSB_64 +: 17];
				w = d[SNC_LSB_64 +: 16];
			end
			SNC_DR_128:
			begin
				top = d[SNC_LSB_128 +: 17];
				w = d[SNC_LSB_128 +: 16];
			end
			SNC_DR_512:
			begin
				top = d[SNC_LSB_512 +: 17];
				w = d[SNC_LSB_512 +: 16];
			end
			SNC_DR_1024:
			begin
				top = d[SNC_LSB_1024 +: 17];
				w = d[SNC_LSB_1024 +: 16];
			end
			SNC_DR_2048:
			begin
				top = d[SNC_LSB_2048 +: 17];
				w = d[SNC_LSB_2048 +: 16];
			end
			SNC_DR_4096:
			begin
				top = d[SNC_LSB_4096 +: 17];
				w = d[SNC_LSB_4096 +: 16];
			end
			default:
			begin
				// top 16 of the 24 full-precision bits
				top = d[SNC_LSB_256 +: 17];
				w = d[SNC_LSB_256 +: 16];
			end
		endcase
		if (r == SNC_DR_32)
			snc_scale = (d[15:0] == SNC_SAT_LOW32) ? SNC_SAT_WORD : {d[14:0], 1'b0};
		else
			snc_scale = (top == SNC_SAT_PATTERN) ? SNC_SAT_WORD : w;
	endfunction

	// ==========================================================
	// modulator clock divider
	// both edges of the link clock become one-cycle events here
	assign half_end = ce && (half_cnt == SNC_MOD_HALF_LAST);
	assign rise_evt = half_end && !modulator_clock_input;
	assign fall_evt = half_end && modulator_clock_input;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			half_cnt <= 8'h00;
			modulator_clock_input <= 1'b0;
		end
		else if (ce)
		begin
			if (half_cnt == SNC_MOD_HALF_LAST)
			begin
				half_cnt <= 8'h00;
				modulator_clock_input <= ~modulator_clock_input;
			end
			else
				half_cnt <= half_cnt + 8'h01;
		end
	end

	// ==========================================================
	// input mapping
	// bit is taken just before our rising edge reaches the device
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			input_sample <= SNC_SAMPLE_ZERO;
		else if (rise_evt)
		begin
			if (modulator_bit_output)
				input_sample <= SNC_SAMPLE_ONE;
			else
				input_sample <= SNC_BIPOLAR ? SNC_SAMPLE_NEG : SNC_SAMPLE_ZERO;
		end
	end

	// ==========================================================
	// integrators, modulus arithmetic wraps harmlessly
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			integ <= '0;
		else if (fall_evt)
		begin
			integ.one <= integ.one + input_sample;
			integ.two <= integ.two + integ.one;
			integ.three <= integ.three + integ.two;
		end
	end

	// ==========================================================
	// decimation counter and word clock
	// ratio is not latched; a change mid-run needs a reset
	assign ratio_last = decimation_ratio - 16'h0001;
	assign ratio_half = (decimation_ratio >> 1) - 16'h0001;
	assign word_evt = rise_evt && (word_count == ratio_half) && !word_clk;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			word_count <= 16'h0000;
		else if (rise_evt)
		begin
			if (word_count == ratio_last)
				word_count <= 16'h0000;
			else
				word_count <= word_count + 16'h0001;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			word_clk <= 1'b0;
		else if (rise_evt)
		begin
			if (word_count == ratio_half)
				word_clk <= 1'b1;
			else if (word_count == ratio_last)
				word_clk <= 1'b0;
		end
	end

	// ==========================================================
	// comb chain, one word per word clock rising edge
	snc_comb_stage #(.W(SNC_ACC_W)) u_comb_one (
		.clk(clk),
		.sys_rst(sys_rst),
		.load(word_evt),
		.din(integ.three),
		.dout(comb_stage_one)
	);

	snc_comb_stage #(.W(SNC_ACC_W)) u_comb_two (
		.clk(clk),
		.sys_rst(sys_rst),
		.load(word_evt),
		.din(comb_stage_one),
		.dout(comb_stage_two)
	);

	snc_comb_stage #(.W(SNC_ACC_W)) u_comb_three (
		.clk(clk),
		.sys_rst(sys_rst),
		.load(word_evt),
		.din(comb_stage_two),
		.dout(comb_stage_three)
	);

	// ==========================================================
	// output word; combs update in the same cycle, old value taken
	always_ff @(posedge clk)
	begin
		// a strobe in the first reset cycle must not load a half-cleared chain
		if (word_evt && !sys_rst)
			filter_word <= snc_scale(decimation_ratio, comb_stage_three);
	end

	// ==========================================================
	// word valid, one modulator period long
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			word_valid <= 1'b0;
			arm <= SNC_ARMED;
		end
		else if (rise_evt)
		begin
			if ((word_count == ratio_half) && (arm == SNC_ARMED))
			begin
				word_valid <= 1'b1;
				arm <= SNC_SPENT;
			end
			else if ((word_count == ratio_last) && (arm == SNC_SPENT))
			begin
				word_valid <= 1'b0;
				arm <= SNC_ARMED;
			end
			else
				word_valid <= 1'b0;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_clk_high;
		modulator_clock_input [*5];
	endsequence

	sequence s_clk_low;
		!modulator_clock_input [*5];
	endsequence

	// run length of the valid pulse, frozen by ce like everything else
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			valid_run <= 8'h00;
		else if (ce)
			valid_run <= word_valid ? valid_run + 8'h01 : 8'h00;
	end

	chk_sample_map: assert property (rise_evt |=>
		input_sample == ($past(modulator_bit_output) ? SNC_SAMPLE_ONE : SNC_SAMPLE_ZERO))
		else $error("input sample mapping wrong");

	chk_integ_chain: assert property (fall_evt |=>
		integ.three == $past(integ.three) + $past(integ.two) &&
		integ.two == $past(integ.two) + $past(integ.one))
		else $error("integrator chain wrong");

	chk_integ_hold: assert property (!fall_evt |=> $stable(integ))
		else $error("integrator moved off falling edge");

	chk_count_wrap: assert property (rise_evt && word_count == ratio_last |=>
		word_count == 16'h0000)
		else $error("decimation counter did not wrap");

	chk_word_clk_set: assert property (rise_evt && word_count == ratio_half |=>
		word_clk)
		else $error("word clock not raised at half count");

	chk_out_load: assert property (word_evt && decimation_ratio == SNC_DR_256 |=>
		filter_word == (($past(comb_stage_three[24:8]) == SNC_SAT_PATTERN) ?
		SNC_SAT_WORD : $past(comb_stage_three[23:8])))
		else $error("output slice wrong at ratio 256");

	chk_out_sat32: assert property (word_evt && decimation_ratio == SNC_DR_32 &&
		comb_stage_three[15:0] == SNC_SAT_LOW32 |=> filter_word == SNC_SAT_WORD)
		else $error("no saturation at ratio 32");

	chk_out_stable: assert property (!word_evt |=> $stable(filter_word))
		else $error("output word changed between words");

	chk_valid_word: assert property (word_evt |=> $rose(word_valid))
		else $error("valid not raised with word");

	chk_valid_len: assert property ($fell(word_valid) |->
		valid_run == (SNC_MOD_HALF_CYC + SNC_MOD_HALF_CYC))
		else $error("valid not one modulator period");

	chk_mod_clk: assert property (disable iff (sys_rst || !ce)
		$rose(modulator_clock_input) |-> s_clk_high ##1 s_clk_low)
		else $error("modulator clock period wrong");

endmodule // snc_filter_host

//--- test/snc_mod_model.sv
// Purpose: behavioural one-bit modulator stream source for the sinc3 host
// Assumes: the host drives the modulator clock
// Notes: ones density is set in quarters, the pattern repeats every four bits
`timescale 1ns/1ps
module snc_mod_model
	import snc_pkg::*;
(
	input wire logic modulator_clock_input,
	input wire logic [2:0] ones_per_four,
	output logic modulator_bit_output
);
	// ==========================================================
	// bit stream
	logic [1:0] phase;

	initial
	begin
		phase = 2'h0;
		modulator_bit_output = 1'b0;
	end

	// new bit after the falling edge, so it stands still for the rising sample
	always @(negedge modulator_clock_input)
	begin
		phase <= phase + 2'h1;
		modulator_bit_output <= ({1'b0, phase} < ones_per_four);
	end
endmodule // snc_mod_model

//--- test/tb_snc_filter_host.sv
// Purpose: self-checking bench for the sinc3 decimation host
// Assumes: 200 MHz clk, ratio held steady between resets
// Notes: words checked once the start-up transients have passed
`timescale 1ns/1ps
module tb_snc_filter_host
	import snc_pkg::*;
;
	// ==========================================================
	// signals
	typedef struct packed {
		logic [15:0] ratio;
		logic [2:0] dens;
		logic [15:0] word;
	} snc_row_t;

	// steady density gives an exact comb result, so words are known
	localparam snc_row_t ROWS [6] = '{
		'{16'h0020, 3'h4, 16'hffff},
		'{16'h0020, 3'h2, 16'h8000},
		'{16'h0040, 3'h2, 16'h8000},
		'{16'h0080, 3'h1, 16'h4000},
		'{16'h0100, 3'h3, 16'hc000},
		'{16'h00c0, 3'h1, 16'h1b00}
	};

	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ce = 1'b1;
	logic [15:0] ratio = 16'h0020;
	logic [2:0] dens = 3'h0;
	logic mbit;
	logic mclk;
	logic [15:0] word;
	logic valid;
	int fail_count = 0;
	int total_checks = 0;
	int cyc = 0;
	int t;

	snc_filter_host uut (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.decimation_ratio(ratio),
		.modulator_bit_output(mbit),
		.modulator_clock_input(mclk),
		.filter_word(word),
		.word_valid(valid)
	);

	snc_mod_model dev (
		.modulator_clock_input(mclk),
		.ones_per_four(dens),
		.modulator_bit_output(mbit)
	);

	always #2.5 clk = ~clk;

	// ==========================================================
	// checking and closing
	task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cmp_num(input string what, input int exp, input int got);
		total_checks++;
		if (got != exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	task automatic results();
		if (fail_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// a whole run needs about 60k cycles
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 90000)
		begin
			fail_count++;
			results();
		end
	end

	// ==========================================================
	// stimulus
	task automatic do_reset();
		logic [15:0] held;
		@(posedge clk);
		sys_rst <= 1'b1;
		#1;
		held = word;
		repeat (6) @(posedge clk);
		#1;
		cmp_word("clock in reset", 16'h0000, {15'h0, mclk});
		cmp_word("valid in reset", 16'h0000, {15'h0, valid});
		cmp_word("word over reset", held, word);
		@(posedge clk) sys_rst <= 1'b0;
	endtask

	task automatic toggles(input int n, output int c);
		logic p;
		c = 0;
		p = mclk;
		repeat (n)
		begin
			@(posedge clk);
			#1;
			if (mclk !== p)
				c++;
			p = mclk;
		end
	endtask

	task automatic run_row(input snc_row_t r);
		int lo;
		int hi;
		@(posedge clk);
		ratio <= r.ratio;
		dens <= r.dens;
		do_reset();
		hi = 0;
		for (int n = 1; n <= 9; n++)
		begin
			lo = 0;
			while (valid !== 1'b1)
			begin
				@(posedge clk);
				#1;
				lo++;
			end
			cmp_word("clock at word", 16'h0001, {15'h0, mclk});
			if (n > 1)
				cmp_num("word spacing", int'(r.ratio) * 10, hi + lo);
			if (n == 9)
				cmp_word("filter word", r.word, word);
			hi = 0;
			while (valid === 1'b1)
			begin
				@(posedge clk);
				#1;
				hi++;
			end
			cmp_num("valid width", 10, hi);
		end
	endtask

	// ==========================================================
	// sequence
	initial
	begin
		foreach (ROWS[i])
			run_row(ROWS[i]);
		@(posedge clk) ce <= 1'b0;
		#1;
		toggles(40, t);
		cmp_num("clock frozen", 0, t);
		@(posedge clk) ce <= 1'b1;
		#1;
		toggles(20, t);
		cmp_num("clock toggles", 4, t);
		results();
	end
endmodule // tb_snc_filter_host
